// ### qect_pkg.sv
package qect_pkg;
  // Register byte offsets
  localparam logic [7:0] QECT_CTRL_OFS    = 8'h00;
  localparam logic [7:0] QECT_PER_SPD_OFS = 8'h04;
  localparam logic [7:0] QECT_PER_POS_OFS = 8'h08;
  localparam logic [7:0] QECT_CNT0_OFS    = 8'h0C;
  localparam logic [7:0] QECT_CNT1_OFS    = 8'h10;
  localparam logic [7:0] QECT_CNT2_OFS    = 8'h14;
  localparam logic [7:0] QECT_PW_CAP_OFS  = 8'h18;
  localparam logic [7:0] QECT_PW_BUF_OFS  = 8'h1C;
  localparam logic [7:0] QECT_C1_SPD_OFS  = 8'h20;
  localparam logic [7:0] QECT_C1_POS_OFS  = 8'h24;
  localparam logic [7:0] QECT_C2_SPD_OFS  = 8'h28;
  localparam logic [7:0] QECT_C2_POS_OFS  = 8'h2C;
  localparam logic [7:0] QECT_STAT_OFS    = 8'h30;
  localparam logic [7:0] QECT_MASK_OFS    = 8'h34;
  // Control field positions
  localparam int QECT_C_RUN0   = 0;
  localparam int QECT_C_MODE1  = 1;  // two bits
  localparam int QECT_C_MODE2  = 3;  // two bits
  localparam int QECT_C_EN1    = 5;
  localparam int QECT_C_EN2    = 6;
  localparam int QECT_C_PWSRC  = 7;
  localparam int QECT_C_CAPEN  = 8;
  localparam int QECT_C_PWEN   = 9;
  localparam int QECT_C_CLRSEL = 10;
  localparam int QECT_C_IDXCLR = 11;
  localparam int QECT_CTRL_W   = 12;
  // Status field positions
  localparam int QECT_S_SPD  = 0;
  localparam int QECT_S_POS  = 1;
  localparam int QECT_S_PW   = 2;
  localparam int QECT_S_IDX1 = 3;
  localparam int QECT_S_IDX2 = 4;
  localparam int QECT_S_W    = 5;
  localparam int QECT_S_DIR1 = 5;
  localparam int QECT_S_DIR2 = 6;
  // Reset values
  localparam logic [QECT_CTRL_W-1:0] QECT_CTRL_RST = 12'h000;
  localparam logic [15:0]            QECT_PER_RST  = 16'hFFFF;
  // Phase counting sub-modes
  typedef enum logic [1:0] {
    QECT_MODE_X4   = 2'h0,
    QECT_MODE_PDIR = 2'h1,
    QECT_MODE_UPDN = 2'h2,
    QECT_MODE_BONLY = 2'h3
  } qect_mode_t;
endpackage

// ### qect_top.sv
`timescale 1ns/100ps
// Summary of operation
// RQ1: Channels 1,2 count encoder inputs up/down
// RQ2: Phase order decides increment or decrement
// RQ3: Four selectable sub-modes, all up/down
// RQ4: Direction flag readable per channel
// RQ5: Mode 1 counts every edge both phases
// RQ6: Mode 4 counts only phase B edges
// RQ7: Mode 2 is pulse plus direction level
// RQ8: Mode 3 has separate up/down pulses
// RQ9: Channel 0 interval timer raises loop interrupt
// RQ10: Channel 0 match captures channel 1 count
// RQ11: External count clocks capture channel 0 time
// RQ12: Channel 1 pins a/b, channel 2 c/d
// RQ13: Encoder drives a/b and index pin
// RQ14: Pulse width capture keeps previous in buffer
// RQ15: Compare match clears channel 0 counter
// RQ16: Encoder gives quadrature phases, one index/turn
// RQ17: Two-stage synchronisers before edge detection
// RQ18: A leading counts up, B leading down
module qect_top
  import qect_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic        ref_clk_in,          // 100 MHz clock
  input  wire logic        reset_in,            // Sync reset, high
  input  wire logic        wb_cyc_in,           // Wishbone cycle
  input  wire logic        wb_stb_in,           // Wishbone strobe
  input  wire logic        wb_we_in,            // Write enable
  input  wire logic [7:0]  wb_adr_in,           // Byte address
  input  wire logic [3:0]  wb_sel_in,           // Byte lanes
  input  wire logic [31:0] wb_dat_in,           // Write data
  output logic      [31:0] wb_dat_out,          // Read data
  output logic             wb_ack_out,          // Acknowledge
  input  wire logic        ext_count_in_a,      // Ch1 phase A
  input  wire logic        ext_count_in_b,      // Ch1 phase B
  input  wire logic        ext_count_in_c,      // Ch2 phase A
  input  wire logic        ext_count_in_d,      // Ch2 phase B
  input  wire logic        index_pulse_irq_in,  // Ch1 index
  input  wire logic        second_index_irq_in, // Ch2 index
  output logic             irq_out              // Level interrupt
);

  // Direction for modes 1 and 4: A_new xor B_old is high when A leads B,
  // so one xor covers both edges of both phases without a table
  // Both phases moving in one cycle is ambiguous and gives no count
  // Step decode: returns {up, down} for one channel
  function automatic logic [1:0] qect_step(input logic [1:0] mode, input logic a, input logic b,
                                           input logic pa, input logic pb);
    logic ea;
    logic eb;
    logic up;
    ea = a ^ pa;
    eb = b ^ pb;
    up = a ^ pb;  // RQ18
    qect_step = 2'h0;
    case (mode)
      QECT_MODE_X4: begin
        if (ea ^ eb) qect_step = up ? 2'h2 : 2'h1;  // RQ5 RQ2
      end
      QECT_MODE_BONLY: begin
        if (eb && !ea) qect_step = up ? 2'h2 : 2'h1;  // RQ6
      end
      QECT_MODE_PDIR: begin
        if (ea && a) qect_step = b ? 2'h2 : 2'h1;  // RQ7
      end
      QECT_MODE_UPDN: begin
        // Simultaneous up and down pulses cancel rather than guess
        qect_step = {ea && a, eb && b};  // RQ8
        if (qect_step == 2'h3) qect_step = 2'h0;
      end
      default: qect_step = 2'h0;
    endcase
  endfunction

  // Pin pipeline: bits 0 to 3 carry inputs a to d, bits 4 and 5 the index pins
  logic [5:0]             s1_reg;
  logic [5:0]             s2_reg;
  logic [5:0]             s3_reg;
  logic [QECT_CTRL_W-1:0] ctrl_reg;
  logic [15:0]            per_spd_reg;
  logic [15:0]            per_pos_reg;
  logic [CW-1:0]          cnt0_reg;
  logic [CW-1:0]          updown_position_counter_reg;
  logic [CW-1:0]          cnt2_reg;
  logic [CW-1:0]          interval_capture_reg;
  logic [CW-1:0]          pw_buf_reg;
  logic [CW-1:0]          c1_spd_reg;
  logic [CW-1:0]          c1_pos_reg;
  logic [CW-1:0]          c2_spd_reg;
  logic [CW-1:0]          c2_pos_reg;
  logic                   dir1_reg;
  logic                   dir2_reg;
  logic [QECT_S_W-1:0]    stat_reg;
  logic [QECT_S_W-1:0]    mask_reg;
  logic [1:0]             step1;
  logic [1:0]             step2;
  logic                   match_spd;
  logic                   match_pos;
  logic                   pw_edge;
  logic                   idx1_rise;
  logic                   idx2_rise;
  logic                   wr_stb;
  logic [QECT_S_W-1:0]    ev;
  logic [QECT_S_W-1:0]    w1c;

  // Two-stage synchronisers; third stage is the edge reference
  // Limitation: each pin level must stand a full cycle or edges merge
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
      s3_reg <= 6'h00;
    end else begin
      s1_reg <= {second_index_irq_in, index_pulse_irq_in, ext_count_in_d, ext_count_in_c,
                 ext_count_in_b, ext_count_in_a};  // RQ17 RQ12
      s2_reg <= s1_reg;  // RQ17
      s3_reg <= s2_reg;
    end
  end

  // Edge and step decode per channel
  // Index acts on its rising edge only, so a held level clears once
  assign step1     = qect_step(ctrl_reg[QECT_C_MODE1 +: 2], s2_reg[0], s2_reg[1],
                               s3_reg[0], s3_reg[1]);  // RQ1 RQ3
  assign step2     = qect_step(ctrl_reg[QECT_C_MODE2 +: 2], s2_reg[2], s2_reg[3],
                               s3_reg[2], s3_reg[3]);  // RQ1 RQ3
  assign idx1_rise = s2_reg[4] & ~s3_reg[4];
  assign idx2_rise = s2_reg[5] & ~s3_reg[5];
  // Any edge of the selected channel's count clocks
  assign pw_edge   = ctrl_reg[QECT_C_PWEN] &
                     (ctrl_reg[QECT_C_PWSRC] ? |(s2_reg[3:2] ^ s3_reg[3:2])
                                             : |(s2_reg[1:0] ^ s3_reg[1:0]));  // RQ11
  // Matches are gated by run so a stopped timer raises no events
  assign match_spd = ctrl_reg[QECT_C_RUN0] && (cnt0_reg == CW'(per_spd_reg));  // RQ9
  assign match_pos = ctrl_reg[QECT_C_RUN0] && (cnt0_reg == CW'(per_pos_reg));

  // Channel 0 interval timer, cleared by the selected match
  // Clear takes the match cycle itself, so a period of N spans N+1 cycles
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt0_reg <= '0;
    end else if (ctrl_reg[QECT_C_RUN0]) begin
      if (ctrl_reg[QECT_C_CLRSEL] ? match_pos : match_spd) begin
        cnt0_reg <= '0;  // RQ15
      end else begin
        cnt0_reg <= cnt0_reg + CW'(1);  // RQ9
      end
    end
  end

  // Channel 1 position counter; index zeroes it when enabled
  // Index wins over a same-cycle step so the zero point stays exact
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      updown_position_counter_reg <= '0;
      dir1_reg                    <= 1'b0;
    end else if (idx1_rise && ctrl_reg[QECT_C_IDXCLR]) begin
      updown_position_counter_reg <= '0;  // RQ13
    end else if (ctrl_reg[QECT_C_EN1] && step1 != 2'h0) begin
      updown_position_counter_reg <= step1[1] ? updown_position_counter_reg + CW'(1)
                                              : updown_position_counter_reg - CW'(1);  // RQ1 RQ2
      dir1_reg                    <= step1[1];  // RQ4
    end
  end

  // Channel 2 command counter
  // Same decoder as channel 1, so command pulses get every sub-mode
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt2_reg <= '0;
      dir2_reg <= 1'b0;
    end else if (idx2_rise && ctrl_reg[QECT_C_IDXCLR]) begin
      cnt2_reg <= '0;
    end else if (ctrl_reg[QECT_C_EN2] && step2 != 2'h0) begin
      cnt2_reg <= step2[1] ? cnt2_reg + CW'(1) : cnt2_reg - CW'(1);  // RQ1 RQ2
      dir2_reg <= step2[1];  // RQ4
    end
  end

  // Loop-period captures of both counters, no external trigger wiring
  // Both counters latch on one edge, so speed and command share a timestamp
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      c1_spd_reg <= '0;
      c1_pos_reg <= '0;
      c2_spd_reg <= '0;
      c2_pos_reg <= '0;
    end else if (ctrl_reg[QECT_C_CAPEN]) begin
      if (match_spd) begin
        c1_spd_reg <= updown_position_counter_reg;  // RQ10
        c2_spd_reg <= cnt2_reg;  // RQ9
      end
      if (match_pos) begin
        c1_pos_reg <= updown_position_counter_reg;  // RQ10
        c2_pos_reg <= cnt2_reg;
      end
    end
  end

  // Pulse width capture with one-deep buffer
  // Buffer keeps the older width so software can compare two samples
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      interval_capture_reg <= '0;
      pw_buf_reg           <= '0;
    end else if (pw_edge) begin
      interval_capture_reg <= cnt0_reg;  // RQ11
      pw_buf_reg           <= interval_capture_reg;  // RQ14
    end
  end

  // Wishbone: ack one cycle after the strobe, dropped the next
  // The write lands on the request edge; the master still holds until ack
  // Ack low for a cycle after each access forces a gap between requests
  assign wr_stb = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
    end
  end

  // Control and period registers, low lanes only hold data
  // Upper lanes are ignored: every register fits in sixteen bits
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl_reg    <= QECT_CTRL_RST;
      per_spd_reg <= QECT_PER_RST;
      per_pos_reg <= QECT_PER_RST;
      mask_reg    <= '0;
    end else if (wr_stb) begin
      case (wb_adr_in)
        QECT_CTRL_OFS: begin
          if (wb_sel_in[0]) ctrl_reg[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1]) ctrl_reg[QECT_CTRL_W-1:8] <= wb_dat_in[QECT_CTRL_W-1:8];
        end
        QECT_PER_SPD_OFS: begin
          if (wb_sel_in[0]) per_spd_reg[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1]) per_spd_reg[15:8] <= wb_dat_in[15:8];
        end
        QECT_PER_POS_OFS: begin
          if (wb_sel_in[0]) per_pos_reg[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1]) per_pos_reg[15:8] <= wb_dat_in[15:8];
        end
        QECT_MASK_OFS: begin
          if (wb_sel_in[0]) mask_reg <= wb_dat_in[QECT_S_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Sticky status; a new event wins over a same-cycle clear
  // Letting the clear win would silently lose an event
  assign ev  = {idx2_rise, idx1_rise, pw_edge, match_pos, match_spd};
  assign w1c = (wr_stb && wb_adr_in == QECT_STAT_OFS && wb_sel_in[0]) ? wb_dat_in[QECT_S_W-1:0]
                                                                     : '0;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~w1c) | ev;  // RQ9
    end
  end

  // Level interrupt while any unmasked event is pending
  // Uses the next status value so the pin adds no further cycle of lag
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((stat_reg & ~w1c) | ev) & mask_reg);  // RQ9
    end
  end

  // Read data, registered with the ack; unmapped reads zero
  // Direction bits sit above the sticky bits and ignore write-one-to-clear
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (wb_cyc_in & wb_stb_in & ~wb_ack_out) begin
      case (wb_adr_in)
        QECT_CTRL_OFS:    wb_dat_out <= 32'(ctrl_reg);
        QECT_PER_SPD_OFS: wb_dat_out <= 32'(per_spd_reg);
        QECT_PER_POS_OFS: wb_dat_out <= 32'(per_pos_reg);
        QECT_CNT0_OFS:    wb_dat_out <= 32'(cnt0_reg);
        QECT_CNT1_OFS:    wb_dat_out <= 32'(updown_position_counter_reg);
        QECT_CNT2_OFS:    wb_dat_out <= 32'(cnt2_reg);
        QECT_PW_CAP_OFS:  wb_dat_out <= 32'(interval_capture_reg);
        QECT_PW_BUF_OFS:  wb_dat_out <= 32'(pw_buf_reg);
        QECT_C1_SPD_OFS:  wb_dat_out <= 32'(c1_spd_reg);
        QECT_C1_POS_OFS:  wb_dat_out <= 32'(c1_pos_reg);
        QECT_C2_SPD_OFS:  wb_dat_out <= 32'(c2_spd_reg);
        QECT_C2_POS_OFS:  wb_dat_out <= 32'(c2_pos_reg);
        QECT_STAT_OFS:    wb_dat_out <= 32'({dir2_reg, dir1_reg, stat_reg});  // RQ4
        QECT_MASK_OFS:    wb_dat_out <= 32'(mask_reg);
        default:          wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### qect_top_props.sv
`timescale 1ns/100ps
module qect_top_props (
  input wire logic        ref_clk_in,  // Clock
  input wire logic        reset_in,    // Sync reset
  input wire logic        wb_cyc_in,   // Cycle
  input wire logic        wb_stb_in,   // Strobe
  input wire logic        wb_we_in,    // Write
  input wire logic [31:0] wb_dat_out,  // Read data
  input wire logic        wb_ack_out,  // Ack
  input wire logic        irq_out      // Interrupt
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  // Bus handshake timing
  a_ack_after_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_rdata_hold: assert property (!wb_ack_out |-> $stable(wb_dat_out))
    else $error("read data moved without access");
  // Reset must quiet the outputs, so the reset disable is overridden
  a_ack_reset_low: assert property (disable iff (1'b0) reset_in |=> !wb_ack_out)
    else $error("ack after reset");
  a_irq_reset_low: assert property (disable iff (1'b0) reset_in |=> !irq_out)
    else $error("irq after reset");
  // Sticky status: irq only drops after a register write
  a_irq_fall_write: assert property ($fell(irq_out) |-> $past(wb_cyc_in && wb_stb_in && wb_we_in))
    else $error("irq dropped without write");
endmodule
bind qect_top qect_top_props u_props (
  .ref_clk_in(ref_clk_in),
  .reset_in  (reset_in),
  .wb_cyc_in (wb_cyc_in),
  .wb_stb_in (wb_stb_in),
  .wb_we_in  (wb_we_in),
  .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out),
  .irq_out   (irq_out)
);

// ### qect_enc_model.sv
`timescale 1ns/100ps
module qect_enc_model (
  input  wire logic clk_in,  // Clock
  input  wire logic fwd_in,  // One step forward
  input  wire logic bwd_in,  // One step back
  input  wire logic idx_in,  // Index request
  output logic      pa_out,  // Phase A
  output logic      pb_out,  // Phase B
  output logic      pz_out   // Index pulse
);
  logic [1:0] ph_reg = 2'h0;
  // Quarter-cycle steps; one step a call keeps edges apart
  always_ff @(posedge clk_in) begin
    if (fwd_in) ph_reg <= ph_reg + 2'h1;
    else if (bwd_in) ph_reg <= ph_reg - 2'h1;
  end
  // Gray order 00,10,11,01: A leads B going forward
  assign pa_out = ph_reg[1] ^ ph_reg[0];
  assign pb_out = ph_reg[1];
  assign pz_out = idx_in;
endmodule

// ### qect_top_bench.sv
`timescale 1ns/100ps
module qect_top_bench import qect_pkg::*; ;
  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, q0;
  logic        ack, irq, pa, pb, pz;
  logic        fwd = 1'b0, bwd = 1'b0, idx = 1'b0, pc = 1'b0, pd = 1'b0, z2 = 1'b0;
  int          error_cnt = 0, total_checks = 0, n;
  // 100 MHz clock
  always #5 ref_clk_in = ~ref_clk_in;
  qect_top dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .ext_count_in_a(pa), .ext_count_in_b(pb), .ext_count_in_c(pc),
    .ext_count_in_d(pd), .index_pulse_irq_in(pz), .second_index_irq_in(z2), .irq_out(irq));
  qect_enc_model enc (.clk_in(ref_clk_in), .fwd_in(fwd), .bwd_in(bwd), .idx_in(idx),
    .pa_out(pa), .pb_out(pb), .pz_out(pz));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge ref_clk_in); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
  endtask
  // Encoder steps spaced wider than the synchroniser depth
  task automatic step(input logic up, input int k);
    repeat (k) begin
      tick(1);
      {fwd, bwd} <= {up, !up};
      tick(1);
      {fwd, bwd} <= 2'b00;
      tick(3);
    end
    tick(4);
  endtask
  task automatic pulse(input logic on_c, input int k);
    repeat (k) begin
      tick(3);
      {pc, pd} <= {pc | on_c, pd | !on_c};
      tick(3);
      {pc, pd} <= {pc & !on_c, pd & on_c};
    end
    tick(4);
  endtask
  task automatic t_mode1;
    rd(QECT_CTRL_OFS, 32'h0);
    rd(QECT_PER_SPD_OFS, 32'hFFFF);
    wb(1'b1, QECT_CTRL_OFS, 32'h020);
    step(1'b1, 3);
    rd(QECT_CNT1_OFS, 32'h3);
    wb(1'b0, QECT_STAT_OFS, 32'h0);
    chk(q[QECT_S_DIR1], 1'b1);
    step(1'b0, 5);
    rd(QECT_CNT1_OFS, 32'hFFFE);
    wb(1'b0, QECT_STAT_OFS, 32'h0);
    chk(q[QECT_S_DIR1], 1'b0);
  endtask
  task automatic t_interval;
    wb(1'b1, QECT_PER_SPD_OFS, 32'h9);
    wb(1'b1, QECT_MASK_OFS, 32'h1);
    wb(1'b1, QECT_CTRL_OFS, 32'h121);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(irq, 1'b1);
    rd(QECT_C1_SPD_OFS, 32'hFFFE);
    wb(1'b0, QECT_CNT0_OFS, 32'h0);
    chk(q > 32'h9, 1'b0);
    wb(1'b1, QECT_CTRL_OFS, 32'h020);
    wb(1'b1, QECT_MASK_OFS, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    wb(1'b1, QECT_MASK_OFS, 32'h1);
    tick(2);
    chk(irq, 1'b1);
    wb(1'b1, QECT_STAT_OFS, 32'h1);
    tick(2);
    chk(irq, 1'b0);
  endtask
  // Second capture must push the first into the buffer
  task automatic t_pwidth;
    wb(1'b1, QECT_CTRL_OFS, 32'h221);
    step(1'b1, 1);
    wb(1'b0, QECT_PW_CAP_OFS, 32'h0);
    q0 = q;
    step(1'b1, 1);
    rd(QECT_PW_BUF_OFS, q0);
    wb(1'b0, QECT_STAT_OFS, 32'h0);
    chk(q[QECT_S_PW], 1'b1);
  endtask
  task automatic t_mode4_index;
    wb(1'b1, QECT_CTRL_OFS, 32'h026);
    step(1'b1, 4);
    rd(QECT_CNT1_OFS, 32'h2);
    wb(1'b1, QECT_CTRL_OFS, 32'h820);
    idx <= 1'b1;
    tick(4);
    idx <= 1'b0;
    tick(4);
    rd(QECT_CNT1_OFS, 32'h0);
  endtask
  // Command pulses on the second pin pair
  task automatic t_ch2;
    wb(1'b1, QECT_CTRL_OFS, 32'h048);
    pd <= 1'b1;
    pulse(1'b1, 3);
    pd <= 1'b0;
    pulse(1'b1, 1);
    rd(QECT_CNT2_OFS, 32'h2);
    wb(1'b1, QECT_CTRL_OFS, 32'h050);
    pulse(1'b1, 2);
    pulse(1'b0, 3);
    rd(QECT_CNT2_OFS, 32'h1);
    rd(8'h40, 32'h0);
  endtask
  // Position-match clear, second pair as width source, second index
  task automatic t_loop2;
    wb(1'b1, QECT_PER_POS_OFS, 32'hC);
    wb(1'b1, QECT_CTRL_OFS, 32'hF81);
    tick(20);
    rd(QECT_C2_POS_OFS, 32'h1);
    rd(QECT_C2_SPD_OFS, 32'h1);
    wb(1'b0, QECT_CNT0_OFS, 32'h0);
    chk(q > 32'hC, 1'b0);
    wb(1'b1, QECT_STAT_OFS, 32'h1F);
    wb(1'b0, QECT_STAT_OFS, 32'h0);
    chk(q[QECT_S_PW], 1'b0);
    pulse(1'b1, 1);
    wb(1'b0, QECT_STAT_OFS, 32'h0);
    chk(q[QECT_S_PW], 1'b1);
    z2 <= 1'b1;
    tick(4);
    z2 <= 1'b0;
    tick(4);
    rd(QECT_CNT2_OFS, 32'h0);
    wb(1'b0, QECT_STAT_OFS, 32'h0);
    chk(q[QECT_S_IDX2], 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after 8 reset cycles
  initial begin
    tick(8);
    reset_in <= 1'b0;
    t_mode1;
    t_interval;
    t_pwidth;
    t_mode4_index;
    t_ch2;
    t_loop2;
    report_and_stop;
  end
  // Run needs under 2000 cycles; generous cut-off
  initial begin
    tick(20000);
    error_cnt++;
    report_and_stop;
  end
endmodule
